// ### core/rops_pkg.sv
// Purpose: Constants for the remappable output pin select bank.
// Assumes: One 16-bit mapping register per pair of remappable pins 8..23.
// Notes: Register indices are local; byte addressing is left to the system bus.
package rops_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int SEL_W = 5;
    localparam int NUM_FUNC = 32;
    localparam int FIRST_PIN = 8;
    localparam int NUM_PINS = 16;
    localparam int NUM_REGS = 8;
    // Register indices of the bank
    localparam logic [ADDR_W-1:0] OUT_MAP_PINS_8_9 = 4'h4;
    localparam logic [ADDR_W-1:0] OUT_MAP_PINS_10_11 = 4'h5;
    localparam logic [ADDR_W-1:0] OUT_MAP_PINS_12_13 = 4'h6;
    localparam logic [ADDR_W-1:0] OUT_MAP_PINS_14_15 = 4'h7;
    localparam logic [ADDR_W-1:0] OUT_MAP_PINS_16_17 = 4'h8;
    localparam logic [ADDR_W-1:0] OUT_MAP_PINS_18_19 = 4'h9;
    localparam logic [ADDR_W-1:0] OUT_MAP_PINS_20_21 = 4'ha;
    localparam logic [ADDR_W-1:0] OUT_MAP_PINS_22_23 = 4'hb;
    // First register absent on the small package
    localparam logic [ADDR_W-1:0] SMALL_PKG_LIMIT = OUT_MAP_PINS_16_17;
    // Field positions
    localparam int LOW_SEL_LSB = 0;
    localparam int HIGH_SEL_LSB = 8;
    localparam logic [DATA_W-1:0] IMPL_MASK = 16'h1f1f;
    localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;
    localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
endpackage

// ### core/rops_reg_bank.sv
// Purpose: Storage for the pin selector fields.
// Assumes: Write enable already qualified by the decoder.
// Notes: Only implemented field bits are stored at all.
`timescale 1ns/100ps
module rops_reg_bank (
    input wire logic clk,
    input wire logic srst,
    input wire logic wrEn,
    input wire logic [3:0] wrIdx,
    input wire logic [15:0] wrData,
    output logic [79:0] selFlat
);
    logic [4:0] sel [16];
    logic [4:0] next_sel [16];

    // Next selector values; one pair per register
    always_comb begin
        for (int i = 0; i < rops_pkg::NUM_PINS; i++) begin
            next_sel[i] = sel[i];
        end
        if (wrEn) begin
            next_sel[{wrIdx[2:0], 1'b0}] = wrData[rops_pkg::LOW_SEL_LSB +: rops_pkg::SEL_W];
            next_sel[{wrIdx[2:0], 1'b1}] = wrData[rops_pkg::HIGH_SEL_LSB +: rops_pkg::SEL_W];
        end
    end

    // Register the selectors, cleared by reset
    always_ff @(posedge clk) begin
        for (int i = 0; i < rops_pkg::NUM_PINS; i++) begin
            if (srst) begin
                sel[i] <= rops_pkg::SEL_RESET;
            end else begin
                sel[i] <= next_sel[i];
            end
        end
    end

    // Flatten for the parent
    always_comb begin
        for (int i = 0; i < rops_pkg::NUM_PINS; i++) begin
            selFlat[i*5 +: 5] = sel[i];
        end
    end
endmodule // rops_reg_bank

// ### core/rops_pin_mux.sv
// Purpose: Routes one peripheral output function onto one pin.
// Assumes: Function outputs arrive on the same clock.
// Notes: Purely combinational; the parent registers the result.
`timescale 1ns/100ps
module rops_pin_mux (
    input wire logic [4:0] sel,
    input wire logic [31:0] funcOut,
    output logic pinValue
);
    // Function n drives the pin when the selector holds n
    always_comb begin
        pinValue = funcOut[sel];
    end
endmodule // rops_pin_mux

// ### core/rops_top.sv
// Purpose: Remappable output pin select for pins 8 to 23.
// Assumes: Register port with one-cycle strobes, read data the cycle after.
// Notes: smallPkg is a configuration level held stable; sampled every cycle.
`timescale 1ns/100ps
module rops_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic smallPkg,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdData,
    input wire logic [31:0] funcOut,
    output logic [15:0] pinOut
);
    logic [79:0] selFlat;
    logic [15:0] pinComb;
    logic hit;
    logic absent;
    logic wrEn;
    logic [15:0] rdWord;
    logic [15:0] next_regRdData;
    logic [15:0] next_pinOut;

    // Address decode; absent registers on the small package are treated as unmapped
    always_comb begin
        hit = 1'b0;
        absent = 1'b0;
        if (regAddr < rops_pkg::OUT_MAP_PINS_8_9) begin
            hit = 1'b0;
        end else if (regAddr > rops_pkg::OUT_MAP_PINS_22_23) begin
            hit = 1'b0;
        end else if (smallPkg && regAddr >= rops_pkg::SMALL_PKG_LIMIT) begin
            absent = 1'b1;
        end else begin
            hit = 1'b1;
        end
        // Absent registers never reach the bank, even if the window above is widened later
        wrEn = regWrite && hit && !absent;
    end

    rops_reg_bank bank (
        .clk(clk),
        .srst(srst),
        .wrEn(wrEn),
        .wrIdx(regAddr - rops_pkg::OUT_MAP_PINS_8_9),
        .wrData(regWrData & rops_pkg::IMPL_MASK),
        .selFlat(selFlat)
    );

    // One mux per pin
    for (genvar p = 0; p < 16; p++) begin : gPin
        rops_pin_mux mux (
            .sel(selFlat[p*5 +: 5]),
            .funcOut(funcOut),
            .pinValue(pinComb[p])
        );
    end

    // Read word assembly; reserved bits forced to zero
    always_comb begin
        logic [3:0] idx;
        idx = regAddr - rops_pkg::OUT_MAP_PINS_8_9;
        rdWord = rops_pkg::REG_RESET;
        if (hit) begin
            rdWord[rops_pkg::LOW_SEL_LSB +: 5] = selFlat[{idx[2:0], 1'b0}*5 +: 5];
            rdWord[rops_pkg::HIGH_SEL_LSB +: 5] = selFlat[{idx[2:0], 1'b1}*5 +: 5];
        end
        next_regRdData = regRead ? (rdWord & rops_pkg::IMPL_MASK) : rops_pkg::REG_RESET;
        // Absent pins stay low so a stale selector can never leak out
        next_pinOut = pinComb;
        if (smallPkg) begin
            next_pinOut[15:8] = 8'h00;
        end
    end

    // Output registers
    always_ff @(posedge clk) begin
        if (srst) begin
            regRdData <= rops_pkg::REG_RESET;
            pinOut <= 16'h0000;
        end else begin
            regRdData <= next_regRdData;
            pinOut <= next_pinOut;
        end
    end

    chk_read_mask: assert property (@(posedge clk) disable iff (srst)
        (regRdData & ~rops_pkg::IMPL_MASK) == 16'h0000)
        else $error("reserved read bits not zero");
    chk_small_read: assert property (@(posedge clk) disable iff (srst)
        regRead && smallPkg && regAddr >= rops_pkg::SMALL_PKG_LIMIT |=>
        regRdData == 16'h0000)
        else $error("absent register read nonzero");
    chk_write_back: assert property (@(posedge clk) disable iff (srst)
        regWrite && hit ##1 regRead && $stable(regAddr) |=>
        regRdData == ($past(regWrData, 2) & rops_pkg::IMPL_MASK))
        else $error("write read-back mismatch");
    chk_pin_route: assert property (@(posedge clk) disable iff (srst)
        !smallPkg |=> pinOut[0] == $past(funcOut[selFlat[4:0]]))
        else $error("pin 8 routing wrong");
    chk_pair_map: assert property (@(posedge clk) disable iff (srst)
        regWrite && regAddr == rops_pkg::OUT_MAP_PINS_10_11 && !smallPkg |=>
        selFlat[19:15] == $past(regWrData[12:8]))
        else $error("pin 11 selector wrong");
    chk_reset_clear: assert property (@(posedge clk)
        srst |=> selFlat == 80'h0 && regRdData == 16'h0000 && pinOut == 16'h0000)
        else $error("reset did not clear");
    chk_absent_write: assert property (@(posedge clk) disable iff (srst)
        regWrite && !hit |=> $stable(selFlat))
        else $error("unmapped write changed state");
    chk_small_pins: assert property (@(posedge clk) disable iff (srst)
        smallPkg ##1 smallPkg |-> pinOut[15:8] == 8'h00)
        else $error("absent pin driven");
endmodule // rops_top

// ### verif/rops_tb_top.sv
// Purpose: Self-checking bench for the remappable output pin select bank.
// Assumes: Read data stands only in the cycle after the read strobe.
// Notes: Selector patterns cover every function number 0..31 over two rounds.
`timescale 1ns/100ps
module rops_tb_top;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic smallPkg = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [15:0] regRdData;
    logic [31:0] funcOut = 32'h0000_0000;
    logic [15:0] pinOut;
    int failures = 0;
    int comparisons = 0;
    // 40 MHz clock
    always #12.5 clk = ~clk;
    rops_top u_dut (.clk(clk), .srst(srst), .smallPkg(smallPkg), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .funcOut(funcOut), .pinOut(pinOut));
    // Shared compare and register port cycles
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input int a, input logic [15:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= 4'(a);
        regWrData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    // Also checks the data drop back to zero one cycle later
    task automatic rd(input int a, input logic [15:0] exp);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= 4'(a);
        @(posedge clk);
        regRead <= 1'b0;
        #1 check("read data", regRdData, exp);
        @(posedge clk);
        #1 check("idle read data", regRdData, 16'h0000);
    endtask
    // Round r shifts every selector by 16 so both rounds cover all functions
    function automatic logic [4:0] selOf(int pin, int r);
        return 5'((pin + 16 * r) % 32);
    endfunction
    function automatic logic [15:0] regVal(int k, int r);
        return {3'h0, selOf(2 * k + 1, r), 3'h0, selOf(2 * k, r)};
    endfunction
    task automatic pin_check(input int r, input logic [31:0] fo, input int live);
        logic [15:0] exp;
        @(posedge clk);
        funcOut <= fo;
        repeat (2) @(posedge clk);
        for (int p = 0; p < 16; p++) exp[p] = (p < live) ? fo[selOf(p + 8, r)] : 1'b0;
        #1 check("pin outputs", pinOut, exp);
    endtask
    task automatic test_reset();
        for (int k = 4; k < 12; k++) rd(k, 16'h0000);
        check("pins after reset", pinOut, 16'h0000);
        $display("test reset done");
    endtask
    task automatic test_fields();
        for (int k = 4; k < 12; k++) begin
            wr(k, 16'hffff);
            rd(k, 16'h1f1f);
            wr(k, 16'he0e0);
            rd(k, 16'h0000);
        end
        $display("test fields done");
    endtask
    task automatic test_routing();
        for (int r = 0; r < 2; r++) begin
            for (int k = 4; k < 12; k++) wr(k, regVal(k, r));
            for (int k = 4; k < 12; k++) rd(k, regVal(k, r));
            pin_check(r, 32'ha5c3_96f0, 16);
            pin_check(r, 32'h5a3c_690f, 16);
        end
        $display("test routing done");
    endtask
    // Small package hides registers 8..11; stored values must survive
    task automatic test_small();
        @(posedge clk);
        smallPkg <= 1'b1;
        for (int k = 8; k < 12; k++) begin
            rd(k, 16'h0000);
            wr(k, 16'h0101);
        end
        wr(0, 16'h1f1f);
        wr(12, 16'h1f1f);
        rd(0, 16'h0000);
        rd(12, 16'h0000);
        pin_check(1, 32'h9966_3cc3, 8);
        @(posedge clk);
        smallPkg <= 1'b0;
        for (int k = 4; k < 12; k++) rd(k, regVal(k, 1));
        $display("test small package done");
    endtask
    // Strobes with no gap: write then read, then write followed by two reads in a row
    task automatic test_back_to_back();
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= 4'h6;
        regWrData <= 16'hffe3;
        @(posedge clk);
        regWrite <= 1'b0;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        regWrite <= 1'b1;
        regAddr <= 4'h7;
        regWrData <= 16'h0a15;
        #1 check("read after write", regRdData, 16'h1f03);
        @(posedge clk);
        regWrite <= 1'b0;
        regRead <= 1'b1;
        @(posedge clk);
        regAddr <= 4'h6;
        #1 check("second read after write", regRdData, 16'h0a15);
        @(posedge clk);
        regRead <= 1'b0;
        #1 check("back to back read", regRdData, 16'h1f03);
        $display("test back to back done");
    endtask
    // Reset in mid-run must clear stored selectors, not only the power-up state
    task automatic test_reset_again();
        @(posedge clk);
        srst <= 1'b1;
        funcOut <= 32'h0000_0001;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        #1 check("pins in reset", pinOut, 16'h0000);
        for (int k = 4; k < 12; k++) rd(k, 16'h0000);
        check("pins route function 0", pinOut, 16'hffff);
        $display("test reset again done");
    endtask
    task automatic summarize();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        test_reset();
        test_fields();
        test_back_to_back();
        test_routing();
        test_small();
        test_reset_again();
        summarize();
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #(25 * 20000);
        failures++;
        summarize();
    end
endmodule // rops_tb_top
